// >>> hdl/pps_consts.vh
// Purpose: Constants for the power sequencer: register offsets, fields, reset values, timing
// Assumes: 100 MHz system clock, 1 ms internal tick
// Notes: Offsets are word indices on the plain register port
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH
`define PPS_CLK_HZ 100000000
`define PPS_TICK_NS 1000000
`define PPS_CLK_NS 10
`define PPS_TICK_CYC (`PPS_TICK_NS / `PPS_CLK_NS)
`define PPS_WAKE_TMO_MS 5000
`define PPS_LONG_PRESS_MS 8000
`define PPS_DEGLITCH_MS 50
`define PPS_PG_BLANK_MS 5
`define PPS_PG_DLY_DEF 8'h14
`define PPS_DLY_MIN 4'h1
`define PPS_DLY_MAX 4'hA
`define PPS_DLY_DEF 4'h1
// Register indices
`define PPS_REG_ENABLE 4'h0
`define PPS_REG_SEQ_CTRL 4'h1
`define PPS_REG_GOOD_CFG 4'h2
`define PPS_REG_STATUS 4'h3
`define PPS_REG_IRQ 4'h4
`define PPS_REG_ASSIGN_A 4'h5
`define PPS_REG_ASSIGN_B 4'h6
`define PPS_REG_DLY_A 4'h7
`define PPS_REG_DLY_B 4'h8
`define PPS_REG_DLY_C 4'h9
// Sequence control bits
`define PPS_BIT_UP 0
`define PPS_BIT_DOWN 1
`define PPS_BIT_INST 2
`define PPS_BIT_OFFT 3
// Good config bits
`define PPS_BIT_M1 0
`define PPS_BIT_M2 1
`define PPS_BIT_LS1 2
`define PPS_BIT_LS2 3
`define PPS_GOOD_CFG_DEF 4'h3
// Default strobe map, one nibble per rail
`define PPS_ASSIGN_DEF 32'h0000F000
`define PPS_STROBE_AUX_A 4'hF
`define PPS_STROBE_AUX_B 4'hE
`endif

// >>> hdl/pps_power_sequencer.v
// Purpose: Strobe power sequencer with wake logic, power-good monitor and button monitor
// Assumes: Button, sense and good inputs are asynchronous; register port on sys_clk_i
// Notes: Rails 0-2 buck, 3-4 aux, 5-6 switchable; nibble 4*i of assign word is rail i
`timescale 1ns/100ps
`include "pps_consts.vh"
module pps_power_sequencer #(
  parameter NRAIL = 7,
  parameter WAKE_TMO_MS = `PPS_WAKE_TMO_MS,
  parameter LONG_PRESS_MS = `PPS_LONG_PRESS_MS,
  parameter TICK_CYC = `PPS_TICK_CYC
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire button_input_n_i,
  input wire usb_sense_i,
  input wire ac_sense_i,
  input wire power_enable_input_i,
  input wire hard_reset_pin_n_i,
  input wire overtemp_shutdown_i,
  input wire undervoltage_lockout_i,
  input wire [6:0] rail_good_i,
  output reg [6:0] rail_en_o,
  output reg main_good_output_o,
  output reg aux_good_output_o
);
  // Device states
  localparam ST_OFF = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_UP = 3'd2;
  localparam ST_ACT = 3'd3;
  localparam ST_DOWN = 3'd4;
  localparam ST_SLEEP = 3'd5;

  // Clamp a programmed delay into the legal 1..10 ms range
  function [3:0] clamp_dly;
    input [3:0] d;
    begin
      if (d < `PPS_DLY_MIN) begin
        clamp_dly = `PPS_DLY_MIN;
      end else if (d > `PPS_DLY_MAX) begin
        clamp_dly = `PPS_DLY_MAX;
      end else begin
        clamp_dly = d;
      end
    end
  endfunction

  // Input synchronisers, two stages each
  reg [12:0] s1_reg;
  reg [12:0] s2_reg;
  always @(posedge sys_clk_i) begin
    s1_reg <= {rail_good_i, undervoltage_lockout_i, overtemp_shutdown_i, hard_reset_pin_n_i,
               power_enable_input_i, ac_sense_i, usb_sense_i};
    s2_reg <= s1_reg;
  end
  wire usb_s = s2_reg[0];
  wire ac_s = s2_reg[1];
  wire power_enable_input_s = s2_reg[2];
  wire hard_rst_n_s = s2_reg[3];
  wire ots_s = s2_reg[4];
  wire undervoltage_lockout_s = s2_reg[5];
  wire [6:0] good_s = s2_reg[12:6];

  // Millisecond tick generator
  reg [31:0] pre_reg;
  reg tick_reg;
  always @(posedge sys_clk_i) begin
    if (rst_i || pre_reg == TICK_CYC - 1) begin
      pre_reg <= 32'h00000000;
    end else begin
      pre_reg <= pre_reg + 32'h00000001;
    end
    tick_reg <= !rst_i && (pre_reg == TICK_CYC - 1);
  end

  // Button deglitch: level accepted after 50 stable ticks
  reg btn_raw1_reg;
  reg btn_raw2_reg;
  reg btn_lvl_reg; // Deglitched level, high is released
  reg [5:0] btn_cnt_reg;
  reg [15:0] press_cnt_reg;
  reg btn_fall_reg;
  reg btn_chg_reg;
  reg long_press_reg;
  always @(posedge sys_clk_i) begin
    btn_raw1_reg <= button_input_n_i;
    btn_raw2_reg <= btn_raw1_reg;
    if (rst_i) begin
      btn_lvl_reg <= 1'b1;
      btn_cnt_reg <= 6'h00;
      btn_fall_reg <= 1'b0;
      btn_chg_reg <= 1'b0;
    end else begin
      btn_fall_reg <= 1'b0;
      btn_chg_reg <= 1'b0;
      if (btn_raw2_reg == btn_lvl_reg) begin
        btn_cnt_reg <= 6'h00;
      end else if (tick_reg) begin
        if (btn_cnt_reg == `PPS_DEGLITCH_MS - 1) begin
          btn_lvl_reg <= btn_raw2_reg;
          btn_cnt_reg <= 6'h00;
          btn_chg_reg <= 1'b1;
          btn_fall_reg <= !btn_raw2_reg;
        end else begin
          btn_cnt_reg <= btn_cnt_reg + 6'h01;
        end
      end
    end
  end

  // Long press: held low beyond the limit, one pulse per hold
  always @(posedge sys_clk_i) begin
    if (rst_i || btn_lvl_reg) begin
      press_cnt_reg <= 16'h0000;
      long_press_reg <= 1'b0;
    end else begin
      long_press_reg <= 1'b0;
      if (tick_reg && press_cnt_reg != 16'hFFFF) begin
        press_cnt_reg <= press_cnt_reg + 16'h0001;
        long_press_reg <= (press_cnt_reg == LONG_PRESS_MS[15:0]);
      end
    end
  end

  // Edge detectors on synchronised senses
  reg usb_d_reg;
  reg ac_d_reg;
  always @(posedge sys_clk_i) begin
    usb_d_reg <= usb_s;
    ac_d_reg <= ac_s;
  end
  wire wake_evt = btn_fall_reg || (usb_s && !usb_d_reg) || (ac_s && !ac_d_reg);

  // Software registers
  reg [31:0] assign_reg; // Strobe nibble per rail
  reg [11:0] dly_a_reg; // Delays one to three
  reg [11:0] dly_b_reg; // Delays four to six
  reg [7:0] good_report_delay_reg; // Report delay in ms
  reg [3:0] seq_ctrl_reg; // Up, down, instant, off-target
  reg [3:0] good_cfg_reg; // Aux masks, load switch modes
  reg irq_reg; // Button change flag
  // Sequencer state
  reg [2:0] state_reg;
  reg [3:0] strobe_reg;
  reg [3:0] step_cnt_reg;
  reg [12:0] tmo_cnt_reg;
  reg to_off_reg; // Power-down target is OFF
  reg [7:0] rep_cnt_reg;
  reg seq_done_reg;
  reg aux_b_pend_reg;
  reg [3:0] aux_b_cnt_reg;
  reg [6:0] blank_done_reg;
  reg [2:0] blank_cnt_reg [0:6];
  wire seq_busy = (state_reg == ST_UP) || (state_reg == ST_DOWN);

  // Delay for the step that follows strobe s (power-up) or precedes it (power-down)
  function [3:0] step_dly;
    input [3:0] s;
    input [11:0] a;
    input [11:0] b;
    begin
      case (s)
        4'd1: step_dly = clamp_dly(a[3:0]);
        4'd2: step_dly = clamp_dly(a[7:4]);
        4'd3: step_dly = clamp_dly(a[11:8]);
        4'd4: step_dly = clamp_dly(b[3:0]);
        4'd5: step_dly = clamp_dly(b[7:4]);
        default: step_dly = clamp_dly(b[11:8]);
      endcase
    end
  endfunction

  // Monitored good faults and power-down causes
  reg [6:0] mon_mask;
  integer i;
  always @* begin
    mon_mask = rail_en_o & blank_done_reg;
    mon_mask[5] = mon_mask[5] && !good_cfg_reg[`PPS_BIT_LS1];
    mon_mask[6] = mon_mask[6] && !good_cfg_reg[`PPS_BIT_LS2];
  end
  wire pg_fault = |(mon_mask & ~good_s);
  wire hard_fault = pg_fault || ots_s || undervoltage_lockout_s || !hard_rst_n_s;
  wire step_delay_six_tick = tick_reg;

  // Main control process
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_OFF;
      rail_en_o <= 7'h00;
      assign_reg <= `PPS_ASSIGN_DEF;
      dly_a_reg <= {3{`PPS_DLY_DEF}};
      dly_b_reg <= {3{`PPS_DLY_DEF}};
      good_report_delay_reg <= `PPS_PG_DLY_DEF;
      seq_ctrl_reg <= 4'h0;
      good_cfg_reg <= `PPS_GOOD_CFG_DEF;
      irq_reg <= 1'b0;
      strobe_reg <= 4'h0;
      step_cnt_reg <= 4'h0;
      tmo_cnt_reg <= 13'h0000;
      to_off_reg <= 1'b0;
      seq_done_reg <= 1'b0;
      aux_b_pend_reg <= 1'b0;
      aux_b_cnt_reg <= 4'h0;
    end else begin
      // Register writes; enable locked while the sequencer runs
      if (wr_i) begin
        if (addr_i == `PPS_REG_ENABLE) begin
          if (!seq_busy) begin
            rail_en_o <= wdata_i[6:0];
          end
        end else if (addr_i == `PPS_REG_SEQ_CTRL) begin
          seq_ctrl_reg <= wdata_i[3:0];
        end else if (addr_i == `PPS_REG_GOOD_CFG) begin
          good_cfg_reg <= wdata_i[3:0];
          good_report_delay_reg <= wdata_i[15:8];
        end else if (addr_i == `PPS_REG_ASSIGN_A) begin
          assign_reg <= wdata_i;
        end else if (addr_i == `PPS_REG_DLY_A) begin
          dly_a_reg <= wdata_i[11:0];
        end else if (addr_i == `PPS_REG_DLY_B) begin
          dly_b_reg <= wdata_i[11:0];
        end
      end
      // Button change flag: set wins over a read clear
      if (btn_chg_reg) begin
        irq_reg <= 1'b1;
      end else if (rd_i && addr_i == `PPS_REG_IRQ) begin
        irq_reg <= 1'b0;
      end
      // Aux strobe fourteen fires one step-six delay after the wake
      if (aux_b_pend_reg && step_delay_six_tick) begin
        if (aux_b_cnt_reg == 4'h1) begin
          aux_b_pend_reg <= 1'b0;
          for (i = 3; i < 5; i = i + 1) begin
            if (assign_reg[4*i +: 4] == `PPS_STROBE_AUX_B) begin
              rail_en_o[i] <= 1'b1;
            end
          end
        end else begin
          aux_b_cnt_reg <= aux_b_cnt_reg - 4'h1;
        end
      end
      case (state_reg)
        ST_OFF, ST_SLEEP: begin
          seq_done_reg <= 1'b0;
          if (hard_fault) begin
            // Good loss on a rail left on, or a fault pin, still cuts every rail
            state_reg <= ST_OFF;
            rail_en_o <= 7'h00;
          end else if (wake_evt || (state_reg == ST_SLEEP && power_enable_input_s)) begin
            tmo_cnt_reg <= 13'h0000;
            if (state_reg == ST_OFF) begin
              for (i = 3; i < 5; i = i + 1) begin
                if (assign_reg[4*i +: 4] == `PPS_STROBE_AUX_A) begin
                  rail_en_o[i] <= 1'b1;
                end
              end
              aux_b_pend_reg <= 1'b1;
              aux_b_cnt_reg <= clamp_dly(dly_b_reg[11:8]);
            end
            state_reg <= power_enable_input_s ? ST_UP : ST_WAIT;
            strobe_reg <= 4'h1;
            step_cnt_reg <= 4'h0;
          end
        end
        ST_WAIT: begin
          if (power_enable_input_s) begin
            state_reg <= ST_UP;
          end else if (hard_fault) begin
            state_reg <= ST_DOWN;
            to_off_reg <= 1'b1;
            strobe_reg <= 4'h7;
            step_cnt_reg <= 4'h0;
          end else if (tick_reg) begin
            tmo_cnt_reg <= tmo_cnt_reg + 13'h0001;
            if (tmo_cnt_reg == WAKE_TMO_MS[12:0] - 13'h0001) begin
              state_reg <= ST_DOWN;
              to_off_reg <= 1'b1;
              strobe_reg <= 4'h7;
              step_cnt_reg <= 4'h0;
            end
          end
        end
        ST_UP: begin
          if (hard_fault) begin
            state_reg <= ST_DOWN;
            to_off_reg <= 1'b1;
            strobe_reg <= 4'h7;
            step_cnt_reg <= 4'h0;
          end else if (step_cnt_reg == 4'h0) begin
            for (i = 0; i < NRAIL; i = i + 1) begin
              if (assign_reg[4*i +: 4] == strobe_reg) begin
                rail_en_o[i] <= 1'b1;
              end
            end
            if (strobe_reg == 4'h7) begin
              state_reg <= ST_ACT;
              seq_done_reg <= 1'b1;
              seq_ctrl_reg[`PPS_BIT_UP] <= 1'b0;
            end else begin
              step_cnt_reg <= step_dly(strobe_reg, dly_a_reg, dly_b_reg);
            end
          end else if (tick_reg) begin
            if (step_cnt_reg == 4'h1) begin
              strobe_reg <= strobe_reg + 4'h1;
            end
            step_cnt_reg <= step_cnt_reg - 4'h1;
          end
        end
        ST_ACT: begin
          if (hard_fault || long_press_reg || !power_enable_input_s ||
              seq_ctrl_reg[`PPS_BIT_DOWN]) begin
            state_reg <= ST_DOWN;
            to_off_reg <= hard_fault || long_press_reg || seq_ctrl_reg[`PPS_BIT_OFFT];
            seq_ctrl_reg[`PPS_BIT_DOWN] <= 1'b0;
            strobe_reg <= 4'h7;
            step_cnt_reg <= 4'h0;
          end else if (seq_ctrl_reg[`PPS_BIT_UP]) begin
            state_reg <= ST_UP;
            seq_done_reg <= 1'b0;
            strobe_reg <= 4'h1;
            step_cnt_reg <= 4'h0;
          end
        end
        ST_DOWN: begin
          seq_done_reg <= 1'b0;
          aux_b_pend_reg <= 1'b0;
          if (step_cnt_reg == 4'h0) begin
            for (i = 0; i < NRAIL; i = i + 1) begin
              if (assign_reg[4*i +: 4] == strobe_reg ||
                  (seq_ctrl_reg[`PPS_BIT_INST] && assign_reg[4*i +: 4] != 4'h0 &&
                   assign_reg[4*i +: 4] < 4'h8)) begin
                rail_en_o[i] <= 1'b0;
              end
            end
            if (strobe_reg == 4'h1 || seq_ctrl_reg[`PPS_BIT_INST]) begin
              if (to_off_reg) begin
                for (i = 0; i < NRAIL; i = i + 1) begin
                  if (!(i == 3 || i == 4) || seq_ctrl_reg[`PPS_BIT_OFFT] ||
                      hard_fault) begin
                    rail_en_o[i] <= 1'b0;
                  end
                end
                state_reg <= ST_OFF;
              end else begin
                state_reg <= ST_SLEEP;
              end
            end else begin
              step_cnt_reg <= step_dly(strobe_reg - 4'h1, dly_a_reg, dly_b_reg);
            end
          end else if (tick_reg) begin
            if (step_cnt_reg == 4'h1) begin
              strobe_reg <= strobe_reg - 4'h1;
            end
            step_cnt_reg <= step_cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  // Per-rail 5 ms blanking after enable
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : blank
      always @(posedge sys_clk_i) begin
        if (rst_i || !rail_en_o[g]) begin
          blank_cnt_reg[g] <= 3'h0;
          blank_done_reg[g] <= 1'b0;
        end else if (tick_reg && !blank_done_reg[g]) begin
          if (blank_cnt_reg[g] == `PPS_PG_BLANK_MS - 1) begin
            blank_done_reg[g] <= 1'b1;
          end else begin
            blank_cnt_reg[g] <= blank_cnt_reg[g] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // Report delay after the sequencer completes gates main good; aux good rises after it or in sleep
  wire [6:0] main_set = {~good_cfg_reg[`PPS_BIT_LS2], ~good_cfg_reg[`PPS_BIT_LS1],
                         ~good_cfg_reg[`PPS_BIT_M2], ~good_cfg_reg[`PPS_BIT_M1], 3'b111};
  wire [6:0] main_mon = main_set & rail_en_o;
  wire main_ok = (|main_mon) && !(|(main_mon & ~good_s));
  wire [1:0] aux_en = rail_en_o[4:3];
  wire aux_ok = (|aux_en) && !(|(aux_en & ~good_s[4:3]));
  always @(posedge sys_clk_i) begin
    if (rst_i || !seq_done_reg) begin
      rep_cnt_reg <= 8'h00;
    end else if (tick_reg && rep_cnt_reg != 8'hFF && rep_cnt_reg < good_report_delay_reg) begin
      rep_cnt_reg <= rep_cnt_reg + 8'h01;
    end
  end
  wire rep_done = seq_done_reg && rep_cnt_reg >= good_report_delay_reg;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      main_good_output_o <= 1'b0;
      aux_good_output_o <= 1'b0;
    end else begin
      main_good_output_o <= (state_reg == ST_ACT) && rep_done && main_ok;
      if (state_reg == ST_OFF) begin
        aux_good_output_o <= 1'b0;
      end else if (!aux_ok) begin
        aux_good_output_o <= 1'b0;
      end else if (rep_done || state_reg == ST_SLEEP) begin
        aux_good_output_o <= 1'b1;
      end
    end
  end

  // Register read mux, data one cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 32'h00000000;
    end else if (addr_i == `PPS_REG_ENABLE) begin
      rdata_o <= {25'h0000000, rail_en_o};
    end else if (addr_i == `PPS_REG_SEQ_CTRL) begin
      rdata_o <= {28'h0000000, seq_ctrl_reg};
    end else if (addr_i == `PPS_REG_GOOD_CFG) begin
      rdata_o <= {16'h0000, good_report_delay_reg, 4'h0, good_cfg_reg};
    end else if (addr_i == `PPS_REG_STATUS) begin
      rdata_o <= {24'h000000, main_good_output_o, aux_good_output_o, seq_busy,
                  state_reg, 1'b0, btn_lvl_reg};
    end else if (addr_i == `PPS_REG_IRQ) begin
      rdata_o <= {31'h00000000, irq_reg};
    end else if (addr_i == `PPS_REG_ASSIGN_A) begin
      rdata_o <= assign_reg;
    end else if (addr_i == `PPS_REG_DLY_A) begin
      rdata_o <= {20'h00000, dly_a_reg};
    end else if (addr_i == `PPS_REG_DLY_B) begin
      rdata_o <= {20'h00000, dly_b_reg};
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule // pps_power_sequencer

// >>> tb/pps_host_model.sv
// Purpose: Host and rail model facing the power sequencer
// Assumes: Rails settle three cycles after their enable rises
// Notes: A dropped or failed rail reads low, as through a pull-down
`timescale 1ns/100ps
module pps_host_model (
  input wire sys_clk_i,
  input wire en_req_i,
  input wire [6:0] fail_i,
  input wire [6:0] rail_en_i,
  output reg power_enable_o,
  output wire [6:0] rail_good_o
);
  reg [6:0] d1_reg; // Settling pipe, first stage
  reg [6:0] d2_reg; // Second stage
  reg [6:0] d3_reg; // Third stage
  initial begin
    power_enable_o = 1'b0;
    d1_reg = 7'h00;
    d2_reg = 7'h00;
    d3_reg = 7'h00;
  end
  // Host drives enable just after the edge; rails settle behind enables
  always @(posedge sys_clk_i) begin
    power_enable_o <= en_req_i;
    d1_reg <= rail_en_i;
    d2_reg <= d1_reg & rail_en_i;
    d3_reg <= d2_reg & rail_en_i;
  end
  // Good only while enabled, settled and not failed
  assign rail_good_o = d3_reg & rail_en_i & ~fail_i;
endmodule // pps_host_model

// >>> tb/pps_seq_assertions.sv
// Purpose: Port-level checks of the power sequencer
// Assumes: Sees only the sequencer's ports, one clock
// Notes: Bound from the bench top file
`timescale 1ns/100ps
module pps_seq_assertions (
  input wire sys_clk_i,
  input wire rst_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire power_enable_input_i,
  input wire hard_reset_pin_n_i,
  input wire [6:0] rail_good_i,
  input wire [6:0] rail_en_o,
  input wire main_good_output_o,
  input wire aux_good_output_o
);
  reg [9:0] bad_cnt_reg; // Cycles a live buck has read bad
  wire [9:0] bad_cnt_next;
  assign bad_cnt_next = (|(rail_en_o[2:0] & ~rail_good_i[2:0])) ? bad_cnt_reg + 10'h001 : 10'h000;
  // Bad-cycle counter
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      bad_cnt_reg <= 10'h000;
    end else begin
      bad_cnt_reg <= bad_cnt_next;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_reset_quiet;
    $fell(rst_i) |-> rail_en_o == 7'h00 && !main_good_output_o && !aux_good_output_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live at reset");
  property p_main_sleep;
    $fell(power_enable_input_i) |-> ##[0:900] !main_good_output_o;
  endproperty
  a_main_sleep: assert property (p_main_sleep) else $error("main good kept high");
  property p_all_off;
    (rail_en_o == 7'h00) [*3] |-> !main_good_output_o && !aux_good_output_o;
  endproperty
  a_all_off: assert property (p_all_off) else $error("good with all rails off");
  property p_aux_src;
    aux_good_output_o |-> rail_en_o[4:3] != 2'b00 || $past(rail_en_o[4:3], 2) != 2'b00;
  endproperty
  a_aux_src: assert property (p_aux_src) else $error("aux good without aux rail");
  property p_main_src;
    main_good_output_o |-> rail_en_o != 7'h00 || $past(rail_en_o) != 7'h00;
  endproperty
  a_main_src: assert property (p_main_src) else $error("main good without rail");
  property p_hard_off;
    $fell(hard_reset_pin_n_i) |-> ##[1:1000] rail_en_o[2:0] == 3'b000;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("bucks kept on in reset");
  property p_fault_cut;
    bad_cnt_reg < 10'h384;
  endproperty
  a_fault_cut: assert property (p_fault_cut) else $error("bad buck not cut");
endmodule // pps_seq_assertions

// >>> tb/pps_power_sequencer_tb_top.sv
// Purpose: Self-checking bench for the power sequencer
// Assumes: Tick shortened to 10 cycles, timeouts to 20 and 30 ticks
// Notes: Register rows first, then wake, sequencing, button and fault cases
`timescale 1ns/100ps
module pps_power_sequencer_tb_top;
  localparam TCK = 10; // Cycles per tick
  reg sys_clk_i, rst_i, wr_i, rd_i, button_input_n_i, usb_sense_i, ac_sense_i;
  reg hard_reset_pin_n_i, overtemp_shutdown_i, undervoltage_lockout_i, en_req;
  reg [3:0] addr_i;
  reg [31:0] wdata_i, d;
  reg [6:0] fail;
  reg [35:0] rows [0:8]; // Address beside reset value
  wire [31:0] rdata_o;
  wire [6:0] rail_en_o, rail_good_i;
  wire main_good_output_o, aux_good_output_o, power_enable_input_i;
  integer err_count, n_compared, i;
  time t0, t1; // Rise times of the first two bucks
  pps_power_sequencer #(.WAKE_TMO_MS(20), .LONG_PRESS_MS(30), .TICK_CYC(TCK)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .button_input_n_i(button_input_n_i),
    .usb_sense_i(usb_sense_i), .ac_sense_i(ac_sense_i),
    .power_enable_input_i(power_enable_input_i), .hard_reset_pin_n_i(hard_reset_pin_n_i),
    .overtemp_shutdown_i(overtemp_shutdown_i), .undervoltage_lockout_i(undervoltage_lockout_i),
    .rail_good_i(rail_good_i), .rail_en_o(rail_en_o),
    .main_good_output_o(main_good_output_o), .aux_good_output_o(aux_good_output_o));
  pps_host_model host_u (.sys_clk_i(sys_clk_i), .en_req_i(en_req), .fail_i(fail),
    .rail_en_i(rail_en_o), .power_enable_o(power_enable_input_i), .rail_good_o(rail_good_i));
  // Clock, 10 ns period
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge rail_en_o[0]) t0 = $time;
  always @(posedge rail_en_o[1]) t1 = $time;
  // Compare one value and count it
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
    end
  endtask
  // Wait, bounded, for masked enables to reach a value
  task wait_en(input [6:0] m, input [6:0] v, input integer n);
    begin
      i = 0;
      while (((rail_en_o & m) !== v) && i < n) begin
        @(posedge sys_clk_i);
        i = i + 1;
      end
      chk("rail_en", v, rail_en_o & m);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #400000;
    err_count = err_count + 1;
    report_and_stop;
  end
  initial begin
    {sys_clk_i, wr_i, rd_i, usb_sense_i, ac_sense_i, en_req} = 6'h00;
    {overtemp_shutdown_i, undervoltage_lockout_i} = 2'b00;
    {rst_i, button_input_n_i, hard_reset_pin_n_i} = 3'b111;
    {addr_i, wdata_i, fail, err_count, n_compared} = 0;
    rows[0] = 36'h000000000; rows[1] = 36'h100000000; rows[2] = 36'h200001403;
    rows[3] = 36'h300000001; rows[4] = 36'h400000000; rows[5] = 36'h50000F000;
    rows[6] = 36'h700000111; rows[7] = 36'h800000111; rows[8] = 36'hF00000000;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (integer r = 0; r < 9; r = r + 1) begin
      rd(rows[r][35:32]);
      chk("reg", rows[r][31:0], d);
    end
    $display("done register rows");
    usb_sense_i <= 1'b1;
    wait_en(7'h08, 7'h08, 50);
    repeat (30 * TCK) @(posedge sys_clk_i);
    rd(4'h3);
    chk("state", 32'h0, d[4:2]);
    usb_sense_i <= 1'b0;
    en_req <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    usb_sense_i <= 1'b1;
    wait_en(7'h08, 7'h08, 50);
    repeat (300) @(posedge sys_clk_i);
    rd(4'h3);
    chk("state", 32'h3, d[4:2]);
    for (i = 0; i < 400 && aux_good_output_o !== 1'b1; i = i + 1) @(posedge sys_clk_i);
    chk("aux_good", 32'h1, aux_good_output_o);
    chk("main", 32'h0, main_good_output_o);
    $display("done wake");
    wr(4'h5, 32'h0000F321);
    wr(4'h7, 32'h00000003);
    wr(4'h1, 32'h00000001);
    wait_en(7'h01, 7'h01, 100);
    wr(4'h0, 32'h00000000);
    wait_en(7'h07, 7'h07, 200);
    chk("gap", 32'h1, (t1 - t0 >= 20 * TCK) && (t1 - t0 <= 40 * TCK));
    repeat (150) @(posedge sys_clk_i);
    rd(4'h1);
    chk("up_bit", 32'h0, d[0]);
    rd(4'h0);
    chk("enable", 32'h0F, d);
    wr(4'h0, 32'h0000004F);
    wait_en(7'h7F, 7'h4F, 5);
    for (i = 0; i < 400 && main_good_output_o !== 1'b1; i = i + 1) @(posedge sys_clk_i);
    chk("main", 32'h1, main_good_output_o);
    en_req <= 1'b0;
    wait_en(7'h7F, 7'h48, 300);
    repeat (5) @(posedge sys_clk_i);
    rd(4'h3);
    chk("state", 32'h5, d[4:2]);
    chk("main", 32'h0, main_good_output_o);
    chk("aux_good", 32'h1, aux_good_output_o);
    en_req <= 1'b1;
    wait_en(7'h7F, 7'h4F, 300);
    wr(4'h1, 32'h00000006);
    for (i = 0; i < 200 && rail_en_o === 7'h4F; i = i + 1) @(posedge sys_clk_i);
    chk("inst_dn", 32'h48, rail_en_o);
    $display("done sequencing");
    button_input_n_i <= 1'b0;
    repeat (20 * TCK) @(posedge sys_clk_i);
    button_input_n_i <= 1'b1;
    repeat (60 * TCK) @(posedge sys_clk_i);
    rd(4'h4);
    chk("glitch", 32'h0, d[0]);
    button_input_n_i <= 1'b0;
    repeat (55 * TCK) @(posedge sys_clk_i);
    rd(4'h3);
    chk("btn_lvl", 32'h0, d[0]);
    button_input_n_i <= 1'b1;
    repeat (60 * TCK) @(posedge sys_clk_i);
    rd(4'h4);
    chk("btn_irq", 32'h1, d[0]);
    rd(4'h4);
    chk("irq_clr", 32'h0, d[0]);
    rd(4'h3);
    chk("state", 32'h0, d[4:2]);
    $display("done button");
    repeat (400) @(posedge sys_clk_i);
    wr(4'h0, 32'h00000001);
    repeat (100) @(posedge sys_clk_i);
    fail <= 7'h01;
    wait_en(7'h7F, 7'h00, 900);
    rd(4'h3);
    chk("state", 32'h0, d[4:2]);
    hard_reset_pin_n_i <= 1'b0;
    repeat (50) @(posedge sys_clk_i);
    hard_reset_pin_n_i <= 1'b1;
    $display("done fault");
    report_and_stop;
  end
endmodule // pps_power_sequencer_tb_top
bind pps_power_sequencer pps_seq_assertions chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .power_enable_input_i(power_enable_input_i),
  .hard_reset_pin_n_i(hard_reset_pin_n_i), .rail_good_i(rail_good_i), .rail_en_o(rail_en_o),
  .main_good_output_o(main_good_output_o), .aux_good_output_o(aux_good_output_o));
